//--- rtl/pefs_top.sv
// Port E low pin function select: AXI4-Lite registers and pad muxes
// Contract
// - Reserved bits read zero, written zero
// - Pin15 field: port, timer 4D, irq out
// - Pin14 field: port or timer 4C
// - Pin13 field: port, timer 4B, manual reset
// - Pin12 field: port or timer 4A
// - Second register: pins 11..8, reserved gaps
// - Pin10/pin8 top bits reset by boot mode
// - Pin11 field: port or timer 3D
// - Pin10 field: port or timer 3C
`default_nettype none
module pefs_top (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  // Boot strap: ROM disabled external-extension mode
  input wire logic I_BOOT_EXT_NOROM,
  // AXI4-Lite write address
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [3:0] I_AWADDR,
  // AXI4-Lite write data
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read address
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [3:0] I_ARADDR,
  // AXI4-Lite read data
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Port logic side, pins 15..8
  input wire logic [7:0] I_PORT_OUT,
  input wire logic [7:0] I_PORT_OE,
  output logic [7:0] O_PORT_IN,
  // Timer channels, order: 3C 3D 4A 4B 4C 4D
  input wire logic [5:0] I_TMR_OUT,
  input wire logic [5:0] I_TMR_OE,
  output logic [5:0] O_TMR_IN,
  // Interrupt controller
  input wire logic I_IRQ_REQ_OUT,
  output logic O_MANUAL_RESET_N,
  // Pads, pins 15..8
  input wire logic [7:0] I_PAD_IN,
  output logic [7:0] O_PAD_OUT,
  output logic [7:0] O_PAD_OE
);
  // Mode registers
  logic [15:0] low4_r;
  logic [15:0] low3_r;
  // Strap synchroniser and one-shot boot load
  logic boot_s1_r;
  logic boot_s2_r;
  logic boot_done_r;
  // Write channel holding state
  logic aw_got_r;
  logic w_got_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  // Pin field decodes
  logic [2:0] md15;
  logic [2:0] md14;
  logic [1:0] md13;
  logic [2:0] md12;
  logic [2:0] md11;
  logic [2:0] md10;
  logic [7:0] sel_per;
  logic [7:0] per_out;
  logic [7:0] per_oe;
  logic [7:0] per_in;
  logic [15:0] rd_word;

  // Strap passes two flops before use; kept out of reset so the strap
  // is already through the synchroniser when reset is released
  always_ff @(posedge I_SYS_CLK) begin
    boot_s1_r <= I_BOOT_EXT_NOROM;
    boot_s2_r <= boot_s1_r;
  end

  // Write address and data taken in either order, one write at a time
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (wr_go) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_got_r <= 1'b1;
        w_data_r <= I_WDATA;
        w_strb_r <= I_WSTRB;
      end
    end
  end

  // Ready only while that channel is empty and no response is pending
  assign O_AWREADY = !aw_got_r && !O_BVALID;
  assign O_WREADY = !w_got_r && !O_BVALID;
  assign wr_go = aw_got_r && w_got_r;

  // Write response, error for unmapped addresses
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_BVALID <= 1'b0;
      O_BRESP <= pefs_pkg::PEFS_RESP_OKAY;
    end else if (wr_go) begin
      O_BVALID <= 1'b1;
      O_BRESP <= (aw_addr_r == pefs_pkg::PEFS_OFF_LOW4 ||
                  aw_addr_r == pefs_pkg::PEFS_OFF_LOW3) ?
                 pefs_pkg::PEFS_RESP_OKAY : pefs_pkg::PEFS_RESP_SLVERR;
    end else if (I_BREADY) begin
      O_BVALID <= 1'b0;
    end
  end

  // Register updates; masks keep reserved bits zero whatever is written
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      low4_r <= pefs_pkg::PEFS_RST_LOW4;
      low3_r <= pefs_pkg::PEFS_RST_LOW3;
      boot_done_r <= 1'b0;
    end else begin
      // Boot bits loaded once after release, from the synced strap
      if (!boot_done_r) begin
        boot_done_r <= 1'b1;
        if (boot_s2_r) begin
          low3_r <= pefs_pkg::PEFS_BOOT_LOW3;
        end
      end else if (wr_go) begin
        if (aw_addr_r == pefs_pkg::PEFS_OFF_LOW4) begin
          if (w_strb_r[0]) low4_r[7:0] <=
            w_data_r[7:0] & pefs_pkg::PEFS_MASK_LOW4[7:0];
          if (w_strb_r[1]) low4_r[15:8] <=
            w_data_r[15:8] & pefs_pkg::PEFS_MASK_LOW4[15:8];
        end
        if (aw_addr_r == pefs_pkg::PEFS_OFF_LOW3) begin
          if (w_strb_r[0]) low3_r[7:0] <=
            w_data_r[7:0] & pefs_pkg::PEFS_MASK_LOW3[7:0];
          if (w_strb_r[1]) low3_r[15:8] <=
            w_data_r[15:8] & pefs_pkg::PEFS_MASK_LOW3[15:8];
        end
      end
    end
  end

  // Read path: one answer the cycle after the address is taken
  assign O_ARREADY = !O_RVALID;
  always_comb begin
    unique case (I_ARADDR)
      pefs_pkg::PEFS_OFF_LOW4: rd_word = low4_r;
      pefs_pkg::PEFS_OFF_LOW3: rd_word = low3_r;
      default: rd_word = 16'h0000;
    endcase
  end
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= pefs_pkg::PEFS_RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_RVALID <= 1'b1;
      O_RDATA <= {16'h0000, rd_word};
      O_RRESP <= (I_ARADDR == pefs_pkg::PEFS_OFF_LOW4 ||
                  I_ARADDR == pefs_pkg::PEFS_OFF_LOW3) ?
                 pefs_pkg::PEFS_RESP_OKAY : pefs_pkg::PEFS_RESP_SLVERR;
    end else if (I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  // Field extraction; prohibited codes fall back to the port line
  assign md15 = low4_r[pefs_pkg::PEFS_P15_LSB +: 3];
  assign md14 = low4_r[pefs_pkg::PEFS_P14_LSB +: 3];
  assign md13 = low4_r[pefs_pkg::PEFS_P13_LSB +: 2];
  assign md12 = low4_r[pefs_pkg::PEFS_P12_LSB +: 3];
  assign md11 = low3_r[pefs_pkg::PEFS_P11_LSB +: 3];
  assign md10 = low3_r[pefs_pkg::PEFS_P10_LSB +: 3];

  // Owner and driver choice per pin, index 0 is pin 8
  always_comb begin
    sel_per = 8'h00;
    per_out = 8'h00;
    per_oe = 8'h00;
    // Pin 15: timer 4D or interrupt request output
    if (md15 == pefs_pkg::PEFS_MD_TIMER) begin
      sel_per[7] = 1'b1;
      per_out[7] = I_TMR_OUT[5];
      per_oe[7] = I_TMR_OE[5];
    end else if (md15 == pefs_pkg::PEFS_MD_IRQ_OUT) begin
      sel_per[7] = 1'b1;
      per_out[7] = I_IRQ_REQ_OUT;
      per_oe[7] = 1'b1;
    end
    // Pin 14: timer 4C
    if (md14 == pefs_pkg::PEFS_MD_TIMER) begin
      sel_per[6] = 1'b1;
      per_out[6] = I_TMR_OUT[4];
      per_oe[6] = I_TMR_OE[4];
    end
    // Pin 13: timer 4B or input-only manual reset
    if (md13 == pefs_pkg::PEFS_MD2_TIMER) begin
      sel_per[5] = 1'b1;
      per_out[5] = I_TMR_OUT[3];
      per_oe[5] = I_TMR_OE[3];
    end else if (md13 == pefs_pkg::PEFS_MD2_MRST) begin
      sel_per[5] = 1'b1;
    end
    // Pin 12: timer 4A
    if (md12 == pefs_pkg::PEFS_MD_TIMER) begin
      sel_per[4] = 1'b1;
      per_out[4] = I_TMR_OUT[2];
      per_oe[4] = I_TMR_OE[2];
    end
    // Pin 11: timer 3D
    if (md11 == pefs_pkg::PEFS_MD_TIMER) begin
      sel_per[3] = 1'b1;
      per_out[3] = I_TMR_OUT[1];
      per_oe[3] = I_TMR_OE[1];
    end
    // Pin 10: timer 3C
    if (md10 == pefs_pkg::PEFS_MD_TIMER) begin
      sel_per[2] = 1'b1;
      per_out[2] = I_TMR_OUT[0];
      per_oe[2] = I_TMR_OE[0];
    end
    // Pins 9 and 8 have no documented peripheral here: port line only
  end

  // Pad muxes follow the registers with no extra stage
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      pefs_pin_mux u_mux (
        .i_sel_periph(sel_per[gi]),
        .i_port_out(I_PORT_OUT[gi]),
        .i_port_oe(I_PORT_OE[gi]),
        .o_port_in(O_PORT_IN[gi]),
        .i_per_out(per_out[gi]),
        .i_per_oe(per_oe[gi]),
        .o_per_in(per_in[gi]),
        .i_pad_in(I_PAD_IN[gi]),
        .o_pad_out(O_PAD_OUT[gi]),
        .o_pad_oe(O_PAD_OE[gi])
      );
    end
  endgenerate

  // Peripheral inputs; pads are raw, timers resynchronise them themselves
  assign O_TMR_IN = {per_in[7:6], per_in[5] & (md13 ==
                     pefs_pkg::PEFS_MD2_TIMER), per_in[4], per_in[3],
                     per_in[2]};
  // Manual reset is active low and idles high when not selected
  assign O_MANUAL_RESET_N = (md13 == pefs_pkg::PEFS_MD2_MRST) ?
                            per_in[5] : 1'b1;
endmodule // pefs_top
`default_nettype wire

//--- include/pefs_pkg.sv
// Package with offsets, field layouts and mode codes for the port E pin mux
`default_nettype none
package pefs_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] PEFS_OFF_LOW4 = 4'h0;
  localparam logic [3:0] PEFS_OFF_LOW3 = 4'h4;
  // Writable bit masks; reserved bits read zero
  localparam logic [15:0] PEFS_MASK_LOW4 = 16'h7737;
  localparam logic [15:0] PEFS_MASK_LOW3 = 16'h7777;
  // Reset values; low3 gains boot bits 10 and 2 in ROM-less external mode
  localparam logic [15:0] PEFS_RST_LOW4 = 16'h0000;
  localparam logic [15:0] PEFS_RST_LOW3 = 16'h0000;
  localparam logic [15:0] PEFS_BOOT_LOW3 = 16'h0404;
  // Field positions (low bit of each field)
  localparam int PEFS_P15_LSB = 12;
  localparam int PEFS_P14_LSB = 8;
  localparam int PEFS_P13_LSB = 4;
  localparam int PEFS_P12_LSB = 0;
  localparam int PEFS_P11_LSB = 12;
  localparam int PEFS_P10_LSB = 8;
  localparam int PEFS_P9_LSB = 4;
  localparam int PEFS_P8_LSB = 0;
  // Mode codes
  localparam logic [2:0] PEFS_MD_PORT = 3'h0;
  localparam logic [2:0] PEFS_MD_TIMER = 3'h1;
  localparam logic [2:0] PEFS_MD_IRQ_OUT = 3'h3;
  localparam logic [1:0] PEFS_MD2_PORT = 2'h0;
  localparam logic [1:0] PEFS_MD2_TIMER = 2'h1;
  localparam logic [1:0] PEFS_MD2_MRST = 2'h2;
  // AXI responses
  localparam logic [1:0] PEFS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PEFS_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- rtl/pefs_pin_mux.sv
// One pad multiplexer between the port line and one peripheral
`default_nettype none
module pefs_pin_mux (
  // Selection
  input wire logic i_sel_periph,
  // Port side
  input wire logic i_port_out,
  input wire logic i_port_oe,
  output logic o_port_in,
  // Peripheral side
  input wire logic i_per_out,
  input wire logic i_per_oe,
  output logic o_per_in,
  // Pad side
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe
);
  // Steer the driver and the input path by the chosen owner
  always_comb begin
    o_pad_out = i_sel_periph ? i_per_out : i_port_out;
    o_pad_oe = i_sel_periph ? i_per_oe : i_port_oe;
    // Unselected side sees a quiet zero so it never acts on pad noise
    o_port_in = i_sel_periph ? 1'b0 : i_pad_in;
    o_per_in = i_sel_periph ? i_pad_in : 1'b0;
  end
endmodule // pefs_pin_mux
`default_nettype wire

//--- verif/pefs_properties.sv
// Checker for bus answers and pad routing of the port E pin mux
`default_nettype none
module pefs_checker (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  // Register bus
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [1:0] O_BRESP,
  // Pin sides
  input wire logic [7:0] I_PORT_OUT,
  input wire logic [7:0] I_PORT_OE,
  input wire logic [5:0] I_TMR_OUT,
  input wire logic [5:0] I_TMR_OE,
  input wire logic [5:0] O_TMR_IN,
  input wire logic I_IRQ_REQ_OUT,
  input wire logic O_MANUAL_RESET_N,
  input wire logic [7:0] I_PAD_IN,
  input wire logic [7:0] O_PAD_OUT,
  input wire logic [7:0] O_PAD_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  // Read taken, answered next cycle with bits 3, 7, 11, 15 and the upper half clear
  sequence s_ar_taken;
    I_ARVALID && O_ARREADY;
  endsequence
  sequence s_rd_clean;
    O_RVALID && ((O_RDATA & 32'hffff8888) == 32'h0);
  endsequence
  // Pads moved although nothing on the drive side moved
  sequence s_pad_moved;
    $changed({O_PAD_OUT, O_PAD_OE}) && $stable({I_PORT_OUT, I_PORT_OE,
      I_TMR_OUT, I_TMR_OE, I_IRQ_REQ_OUT});
  endsequence
  chk_rd_clean: assert property (s_ar_taken |=> s_rd_clean)
    else $error("read answer late or reserved bit set");
  chk_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID)
    else $error("read answer dropped early");
  chk_b_hold: assert property (O_BVALID && !I_BREADY |=> $stable(O_BRESP))
    else $error("write response changed while waiting");
  chk_low_port: assert property ({O_PAD_OUT[1:0], O_PAD_OE[1:0]}
    == {I_PORT_OUT[1:0], I_PORT_OE[1:0]}) else $error("pins 9 8 not port");
  chk_tmr4d_in: assert property (O_TMR_IN[5] |-> I_PAD_IN[7])
    else $error("timer 4D input not from pin 15");
  chk_tmr4c_in: assert property (O_TMR_IN[4] |-> I_PAD_IN[6])
    else $error("timer 4C input not from pin 14");
  chk_tmr4b_in: assert property (O_TMR_IN[3] |-> I_PAD_IN[5])
    else $error("timer 4B input not from pin 13");
  chk_man_rst_pad: assert property (!O_MANUAL_RESET_N
    |-> !I_PAD_IN[5]) else $error("manual reset without low pin 13");
  chk_tmr4a_in: assert property (O_TMR_IN[2] |-> I_PAD_IN[4])
    else $error("timer 4A input not from pin 12");
  chk_tmr3d_in: assert property (O_TMR_IN[1] |-> I_PAD_IN[3])
    else $error("timer 3D input not from pin 11");
  chk_tmr3c_in: assert property (O_TMR_IN[0] |-> I_PAD_IN[2])
    else $error("timer 3C input not from pin 10");
  chk_pad_write: assert property (s_pad_moved |-> $rose(O_BVALID))
    else $error("pad routing moved without a write");
endmodule // pefs_checker
bind pefs_top pefs_checker chk_u (.*);
`default_nettype wire

//--- verif/pefs_pad_model.sv
// Board side of the pads: own drive loops back, idle pins float outside
`default_nettype none
module pefs_pad_model (
  // Drive from the block
  input wire logic [7:0] i_pad_out,
  input wire logic [7:0] i_pad_oe,
  // Level of outside parts, changed by the bench every check
  input wire logic [7:0] i_ext,
  // Level at each pad
  output logic [7:0] o_pad_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pins never keep the last driven value
  assign o_pad_lvl = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext);
endmodule // pefs_pad_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the port E low pin function select
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus, strap and pin signals
  logic clk = 0, rstn = 0, boot = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic aw_rdy, w_rdy, bv, ar_rdy, rv, irq = 0, man_rst_n;
  logic [3:0] awa = 0, ara = 0, strb = 4'hf;
  logic [31:0] wd = 0, rd;
  logic [1:0] bresp, rresp;
  logic [7:0] p_out = 0, p_oe = 0, ext = 0, p_in, pad_in, pad_out, pad_oe;
  logic [5:0] t_out = 0, t_oe = 0, t_in;
  // Expected read answers, oldest first
  logic [33:0] exp_q[$];
  int error_cnt = 0, checks_done = 0, cyc = 0;
  pefs_top dut_u (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_BOOT_EXT_NOROM(boot),
    .I_AWVALID(awv), .O_AWREADY(aw_rdy), .I_AWADDR(awa), .I_WVALID(wv),
    .O_WREADY(w_rdy), .I_WDATA(wd), .I_WSTRB(strb), .O_BVALID(bv),
    .I_BREADY(br), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(ar_rdy),
    .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rd),
    .O_RRESP(rresp), .I_PORT_OUT(p_out), .I_PORT_OE(p_oe), .O_PORT_IN(p_in),
    .I_TMR_OUT(t_out), .I_TMR_OE(t_oe), .O_TMR_IN(t_in),
    .I_IRQ_REQ_OUT(irq), .O_MANUAL_RESET_N(man_rst_n), .I_PAD_IN(pad_in),
    .O_PAD_OUT(pad_out), .O_PAD_OE(pad_oe));
  pefs_pad_model pad_u (.i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_ext(ext),
    .o_pad_lvl(pad_in));
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  // Hang guard, far above the roughly 140 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  // Each read answer against the oldest note
  always @(posedge clk)
    if (rv && rr) cmp("rdata", exp_q.pop_front(), {rresp, rd});
  task automatic cmp(input string nm, input logic [33:0] e,
    input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset with the strap held well before release
  task automatic rst(input logic b);
    rstn <= 1'b0;
    boot <= b;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // Write: each channel released when taken, then wait for the response
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] er);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    do begin
      @(posedge clk);
      if (aw_rdy) awv <= 1'b0;
      if (w_rdy) wv <= 1'b0;
    end while ((awv && !aw_rdy) || (wv && !w_rdy));
    br <= 1'b1;
    do @(posedge clk); while (!bv);
    br <= 1'b0;
    cmp("bresp", 34'(er), 34'(bresp));
  endtask
  // Read: note the expectation, the monitor compares the answer
  task automatic rd_chk(input logic [3:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    arv <= 1'b1;
    ara <= a;
    do @(posedge clk); while (!ar_rdy);
    arv <= 1'b0;
    rr <= 1'b1;
    do @(posedge clk); while (!rv);
    rr <= 1'b0;
  endtask
  // Random drive, then pin routing; src -1 port, 0..5 timer, 6 irq, 7 reset
  task automatic pad_chk(input int pin, input int src);
    logic eo, ee, lv;
    {p_out, p_oe, t_out, t_oe, irq, ext} <= 37'({$urandom, $urandom});
    @(negedge clk);
    eo = src < 0 ? p_out[pin] : src < 6 ? t_out[src] : src == 6 && irq;
    ee = src < 0 ? p_oe[pin] : src < 6 ? t_oe[src] : src == 6;
    lv = ee ? eo : ext[pin];
    cmp("pad", 34'({ee & eo, ee}),
      34'({pad_out[pin] & pad_oe[pin], pad_oe[pin]}));
    if (src >= 0 && src < 6) cmp("tmr_in", 34'(lv), 34'(t_in[src]));
    if (src == 7) cmp("man_rst_n", 34'(lv), 34'(man_rst_n));
    if (src < 0) cmp("port_in", 34'(lv), 34'(p_in[pin]));
    @(posedge clk);
  endtask
  // One field setting: write, read back, check the pin
  task automatic mode(input logic [3:0] a, input logic [15:0] d,
    input int pin, input int src);
    wr(a, {16'h0, d}, 2'h0);
    rd_chk(a, {18'h0, d});
    pad_chk(pin, src);
  endtask
  initial begin
    void'($urandom(78729));
    rst(1'b1);
    rd_chk(4'h4, 34'h0404);
    rd_chk(4'h0, 34'h0);
    // Legal codes only; reserved positions always written zero
    wr(4'h0, 32'h0000_3121, 2'h0);
    rd_chk(4'h0, 34'h3121);
    wr(4'h4, 32'h0000_1111, 2'h0);
    rd_chk(4'h4, 34'h1111);
    // Upper byte lane only: pins 11 and 10 back to port, 9 and 8 kept
    strb <= 4'h2;
    wr(4'h4, 32'h0000_0000, 2'h0);
    strb <= 4'hf;
    rd_chk(4'h4, 34'h0011);
    wr(4'h8, 32'h1111, pefs_pkg::PEFS_RESP_SLVERR);
    rd_chk(4'h8, {pefs_pkg::PEFS_RESP_SLVERR, 32'h0});
    mode(4'h0, 16'h0000, 7, -1);
    mode(4'h0, 16'h1000, 7, 5);
    mode(4'h0, 16'h3000, 7, 6);
    mode(4'h0, 16'h0100, 6, 4);
    mode(4'h0, 16'h0000, 6, -1);
    mode(4'h0, 16'h0010, 5, 3);
    mode(4'h0, 16'h0020, 5, 7);
    mode(4'h0, 16'h0001, 4, 2);
    mode(4'h0, 16'h0000, 4, -1);
    mode(4'h4, 16'h1000, 3, 1);
    mode(4'h4, 16'h0100, 2, 0);
    mode(4'h4, 16'h0000, 2, -1);
    mode(4'h4, 16'h0011, 1, -1);
    rst(1'b0);
    rd_chk(4'h4, 34'h0);
    @(posedge clk);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
